// File: feedback_position_scaling.sv
// primary feedback position offset, unit, fieldbus reduction and pole check
`timescale 1ns/1ps
`include "fb_scale_map.svh"
module feedback_position_scaling (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [63:0] regWdata,
  output logic [63:0] regRdata,
  output logic regAck,
  output logic regError,
  input wire logic [63:0] rawPosition,
  input wire logic [63:0] followError,
  input wire logic [31:0] gearNumerator,
  input wire logic [15:0] motorPoleCount,
  input wire logic driveEnableReq,
  input wire logic faultClear,
  input wire logic [5:0] stBitsIn,
  input wire logic [5:0] mtBitsIn,
  input wire logic multiturnDevice,
  input wire logic mtInitSupported,
  output logic [63:0] primaryPosition,
  output logic [63:0] positionReport,
  output logic [31:0] fieldbusPosition,
  output logic [31:0] fieldbusFollowError,
  output logic [15:0] commutationPoles,
  output logic [15:0] velocityPoles,
  output logic enableGranted,
  output logic driveFault,
  output logic mtInitPulse,
  output fb_scale_pkg::pos_unit_type positionUnit
);
  import fb_scale_pkg::*;

  // settings; nonvolatile storage is modelled by reset defaults
  logic [15:0] poleCount_reg;
  logic [7:0] posShift_reg;
  logic [63:0] posOffset_reg;
  pos_unit_type posUnit_reg;
  enable_state_type state_reg;
  enable_state_type state_next;
  logic enableReqDly_reg;
  logic checkStart_reg;
  logic pastValid_reg;
  logic wrOk;
  logic [63:0] rdValue;
  logic rdHit;
  logic [5:0] stBitsClamp;
  logic [5:0] mtBitsClamp;
  logic [63:0] posSum;
  logic [95:0] gearProduct;

  pole_check_if chk ();

  pole_ratio_check u_check (
    .clk(clk),
    .sys_rst(sys_rst),
    .chk(chk)
  );

  // right shift by 32 minus the shift setting, keep the low word
  function automatic logic [31:0] reduce(input logic [63:0] pos,
                                         input logic [7:0] sh);
    logic [5:0] amount;
    logic [63:0] shifted;
    amount = 6'(8'h20 - sh);
    shifted = pos >> amount;
    return shifted[31:0];
  endfunction

  // bit counts from the feedback device, clamped to 32
  always_comb begin
    stBitsClamp = (stBitsIn > `BITS_MAX) ? `BITS_MAX : stBitsIn;
    if (!multiturnDevice) begin
      mtBitsClamp = 6'h00;
    end else if (mtBitsIn > `BITS_MAX) begin
      mtBitsClamp = `BITS_MAX;
    end else begin
      mtBitsClamp = mtBitsIn;
    end
  end

  // write value range check; out-of-range writes leave the setting alone
  always_comb begin
    case (regAddr)
      `REG_POLE_COUNT: wrOk = (regWdata[63:16] == 48'h0) &&
        (regWdata[15:0] >= `POLE_MIN) && (regWdata[15:0] <= `POLE_MAX);
      `REG_POS_SHIFT: wrOk = (regWdata[63:8] == 56'h0) &&
        (regWdata[7:0] <= `SHIFT_MAX);
      // offset is taken as one whole word
      `REG_POS_OFFSET: wrOk = 1'b1;
      `REG_POS_UNIT: wrOk = (regWdata == 64'h0) || (regWdata == 64'h3);
      `REG_MT_INIT: wrOk = (regWdata[63:1] == 63'h0);
      default: wrOk = 1'b0;
    endcase
  end

  // read mux; read-only counts report the live device figures
  always_comb begin
    rdHit = 1'b1;
    case (regAddr)
      `REG_POLE_COUNT: rdValue = {48'h0, poleCount_reg};
      `REG_POS_SHIFT: rdValue = {56'h0, posShift_reg};
      `REG_POS_OFFSET: rdValue = posOffset_reg;
      `REG_POS_UNIT: rdValue = {62'h0, posUnit_reg};
      `REG_ST_BITS: rdValue = {58'h0, stBitsClamp};
      // multiturn count, zero on singleturn feedback
      `REG_MT_BITS: rdValue = {58'h0, mtBitsClamp};
      `REG_MT_INIT: rdValue = 64'h0;
      default: begin
        rdValue = 64'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      poleCount_reg <= `RST_POLE_COUNT;
      posShift_reg <= `RST_POS_SHIFT;
      posOffset_reg <= `RST_POS_OFFSET;
      posUnit_reg <= UNIT_COUNTS;
    end else if (regWrite && wrOk) begin
      case (regAddr)
        `REG_POLE_COUNT: poleCount_reg <= regWdata[15:0];
        `REG_POS_SHIFT: posShift_reg <= regWdata[7:0];
        `REG_POS_OFFSET: posOffset_reg <= regWdata;
        `REG_POS_UNIT: posUnit_reg <= pos_unit_type'(regWdata[1:0]);
        default: posUnit_reg <= posUnit_reg;
      endcase
    end
  end

  // bus answers, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 64'h0;
      regAck <= 1'b0;
      regError <= 1'b0;
    end else begin
      regAck <= regWrite || regRead;
      regError <= (regWrite && !wrOk) || (regRead && !rdHit);
      if (regRead) begin
        regRdata <= rdValue;
      end
    end
  end

  // overflow memory init only on capable feedback
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mtInitPulse <= 1'b0;
    end else begin
      mtInitPulse <= regWrite && wrOk && (regAddr == `REG_MT_INIT) &&
        regWdata[0] && mtInitSupported;
    end
  end

  // offset added to the raw position
  assign posSum = rawPosition + posOffset_reg;
  // gear units scale the 32.32 value by the numerator
  assign gearProduct = 96'($signed(posSum) * $signed({1'b0, gearNumerator}));

  // position outputs; turns high word, angle low word, except gear units on the report in unit 3
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primaryPosition <= 64'h0;
      positionReport <= 64'h0;
      positionUnit <= UNIT_COUNTS;
    end else begin
      primaryPosition <= posSum;
      positionUnit <= posUnit_reg;
      if (posUnit_reg == UNIT_GEAR) begin
        positionReport <= gearProduct[95:32];
      end else begin
        positionReport <= posSum;
      end
    end
  end

  // reduction to 32 bits for the fieldbus
  // actual position and following error both reduced
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fieldbusPosition <= 32'h0;
      fieldbusFollowError <= 32'h0;
    end else begin
      // two to the shift counts per turn
      fieldbusPosition <= reduce(primaryPosition, posShift_reg);
      fieldbusFollowError <= reduce(followError, posShift_reg);
    end
  end

  // single poles feed commutation and velocity scaling
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      commutationPoles <= `RST_POLE_COUNT;
      velocityPoles <= `RST_POLE_COUNT;
    end else begin
      commutationPoles <= poleCount_reg;
      velocityPoles <= poleCount_reg;
    end
  end

  // one start pulse on entry to the check; a level would restart it
  assign chk.start = checkStart_reg;
  assign chk.dividend = motorPoleCount;
  assign chk.divisor = poleCount_reg;

  // enable sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (driveEnableReq && !enableReqDly_reg && !driveFault) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (chk.done) begin
          state_next = chk.fault ? ST_FAULT : ST_RUN;
        end
      end
      ST_RUN: begin
        if (!driveEnableReq) begin
          state_next = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (faultClear) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      enableReqDly_reg <= 1'b0;
      checkStart_reg <= 1'b0;
      pastValid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      enableReqDly_reg <= driveEnableReq;
      checkStart_reg <= (state_reg == ST_IDLE) && (state_next == ST_CHECK);
      pastValid_reg <= 1'b1;
    end
  end

  // fault flag: a new fault wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      driveFault <= 1'b0;
      enableGranted <= 1'b0;
    end else begin
      if (state_reg == ST_CHECK && chk.done && chk.fault) begin
        driveFault <= 1'b1;
      end else if (faultClear) begin
        driveFault <= 1'b0;
      end
      enableGranted <= (state_next == ST_RUN);
    end
  end

  a_offset_sum: assert property (
    @(posedge clk) disable iff (sys_rst)
    pastValid_reg |-> primaryPosition ==
      $past(rawPosition) + $past(posOffset_reg))
    else $error("primary position is not raw plus offset");

  a_fieldbus_reduce: assert property (
    @(posedge clk) disable iff (sys_rst)
    pastValid_reg |-> fieldbusPosition == 32'($past(primaryPosition) >>
      (8'h20 - $past(posShift_reg))))
    else $error("fieldbus position not reduced by shift");

  a_pole_range: assert property (
    @(posedge clk) disable iff (sys_rst)
    poleCount_reg >= 16'h0002 && poleCount_reg <= 16'h0080)
    else $error("pole count outside two to 128");

  a_shift_range: assert property (
    @(posedge clk) disable iff (sys_rst)
    posShift_reg <= 8'h20)
    else $error("position shift above 32");

  a_unit_legal: assert property (
    @(posedge clk) disable iff (sys_rst)
    posUnit_reg == UNIT_COUNTS || posUnit_reg == UNIT_GEAR)
    else $error("position unit not zero or three");

  a_ratio_fault: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(driveEnableReq) && state_reg == ST_IDLE && !driveFault |->
      ##19 (driveFault != enableGranted) && !$past(chk.start, 1))
    else $error("enable check gave no verdict in time");

  a_grant_clean: assert property (
    @(posedge clk) disable iff (sys_rst)
    enableGranted |-> !driveFault)
    else $error("enable granted while faulted");

  a_mtinit_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    mtInitPulse |-> $past(mtInitSupported) && $past(regWrite))
    else $error("overflow init on unsupported feedback");
endmodule

// File: fb_scale_map.svh
// register offsets, reset values and limits of the feedback position scaler
// Contract
// - Add the signed 64-bit offset to the primary feedback position.
// - Offset setting defaults to zero after reset.
// - Feedback pole count accepts 2 to 128, defaults to 2.
// - Pole count means single poles; feeds commutation and velocity scaling.
// - On enable request, fault unless motor poles divide evenly by feedback poles.
// - Fieldbus position shift accepts 0 to 32, defaults to 20.
// - Reduce native 64-bit positions to 32 bits for the fieldbus.
// - Reduced position has two to the shift setting counts per turn.
// - Native position: angle in low 32 bits, turns in high 32.
// - Reduction applies to actual position and following error values.
// - Read-only singleturn bit count, 0 to 32, default 0.
// - Position unit accepts only 0 and 3, defaults to 0.
// - Multiturn overflow init acts only on feedback that supports it.
// - Unit 0 gives 32.32 counts; unit 3 gives gear units per turn.
// - Read-only multiturn bit count, zero for singleturn devices.
`ifndef FB_SCALE_MAP_SVH
`define FB_SCALE_MAP_SVH
`define REG_POLE_COUNT 16'h012E
`define REG_POS_SHIFT 16'h0130
`define REG_POS_OFFSET 16'h0652
`define REG_POS_UNIT 16'h0658
`define REG_ST_BITS 16'h065A
`define REG_MT_INIT 16'h065C
`define REG_MT_BITS 16'h06BE
`define RST_POLE_COUNT 16'h0002
`define RST_POS_SHIFT 8'h14
`define RST_POS_OFFSET 64'h0000000000000000
`define POLE_MIN 16'h0002
`define POLE_MAX 16'h0080
`define SHIFT_MAX 8'h20
`define BITS_MAX 6'h20
`define ANGLE_BITS 32
`define DIV_STEPS 5'h10
`endif

// File: fb_scale_pkg.sv
// types shared by the feedback position scaler
package fb_scale_pkg;
  typedef enum logic [1:0] {
    UNIT_COUNTS = 2'h0,
    UNIT_GEAR = 2'h3
  } pos_unit_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_RUN = 4'b0100,
    ST_FAULT = 4'b1000
  } enable_state_type;
endpackage

// File: pole_check_if.sv
// request and answer wires between the enable sequencer and the pole checker
`timescale 1ns/1ps
interface pole_check_if;
  logic start;
  logic [15:0] dividend;
  logic [15:0] divisor;
  logic done;
  logic fault;
  modport requester (output start, output dividend, output divisor,
    input done, input fault);
  modport responder (input start, input dividend, input divisor,
    output done, output fault);
endinterface

// File: pole_ratio_check.sv
// serial remainder check of motor poles over feedback poles
`timescale 1ns/1ps
`include "fb_scale_map.svh"
module pole_ratio_check (
  input wire logic clk,
  input wire logic sys_rst,
  pole_check_if.responder chk
);
  logic [16:0] rem_reg;
  logic [15:0] quo_reg;
  logic [4:0] count_reg;
  logic busy_reg;
  logic done_reg;
  logic fault_reg;
  logic [16:0] remShift;
  logic [16:0] remNext;

  // one restoring division step; divisor never exceeds 128
  always_comb begin
    remShift = {rem_reg[15:0], quo_reg[15]};
    if (remShift >= {1'b0, chk.divisor}) begin
      remNext = remShift - {1'b0, chk.divisor};
    end else begin
      remNext = remShift;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rem_reg <= 17'h00000;
      quo_reg <= 16'h0000;
      count_reg <= 5'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (chk.start && !busy_reg) begin
        rem_reg <= 17'h00000;
        quo_reg <= chk.dividend;
        count_reg <= `DIV_STEPS;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        rem_reg <= remNext;
        quo_reg <= {quo_reg[14:0], 1'b0};
        count_reg <= count_reg - 5'h01;
        if (count_reg == 5'h01) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          fault_reg <= (remNext != 17'h00000);
        end
      end
    end
  end

  assign chk.done = done_reg;
  assign chk.fault = fault_reg;

  a_check_latency: assert property (
    @(posedge clk) disable iff (sys_rst)
    (chk.start && !busy_reg) |-> ##17 done_reg)
    else $error("pole check did not finish in seventeen cycles");
endmodule

// File: feedback_device_model.sv
// model of the feedback device: native position and bit count reports
`timescale 1ns/1ps
module feedback_device_model (
  input wire logic clk,
  output logic [63:0] rawPosition,
  output logic [63:0] followError,
  output logic [5:0] stBitsIn,
  output logic [5:0] mtBitsIn,
  output logic multiturnDevice,
  output logic mtInitSupported
);
  // device powers up at angle zero, turn zero, singleturn, no init support
  initial begin
    rawPosition = 64'h0000000000000000;
    followError = 64'h0000000000000000;
    stBitsIn = 6'h00;
    mtBitsIn = 6'h00;
    multiturnDevice = 1'b0;
    mtInitSupported = 1'b0;
  end

  // turns high, angle low
  // values move just after an edge so the scaler never samples a change
  task automatic setPos(input logic [63:0] p, input logic [63:0] f);
    @(posedge clk);
    rawPosition <= p;
    followError <= f;
  endtask

  // bit counts, turn kind, init support
  task automatic setDev(input logic [5:0] st, input logic [5:0] mt,
      input logic multi, input logic sup);
    @(posedge clk);
    stBitsIn <= st;
    mtBitsIn <= mt;
    multiturnDevice <= multi;
    mtInitSupported <= sup;
  endtask
endmodule

// File: feedback_position_scaling_bench.sv
// self-checking bench of the feedback position scaler
`timescale 1ns/1ps
`include "fb_scale_map.svh"
module feedback_position_scaling_bench;
  import fb_scale_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [63:0] regWdata = 64'h0;
  logic [63:0] regRdata, primaryPosition, positionReport;
  logic regAck, regError, enableGranted, driveFault, mtInitPulse;
  logic [63:0] rawPosition, followError;
  logic [31:0] gearNumerator = 32'h000003E8;
  logic [15:0] motorPoleCount = 16'h0006;
  logic driveEnableReq = 1'b0;
  logic faultClear = 1'b0;
  logic [5:0] stBitsIn, mtBitsIn;
  logic multiturnDevice, mtInitSupported;
  logic [31:0] fieldbusPosition, fieldbusFollowError;
  logic [15:0] commutationPoles, velocityPoles;
  pos_unit_type positionUnit;
  logic gotAck, gotErr, gotInit;
  logic [63:0] gotData;
  int fails = 0;
  int numChecks = 0;

  feedback_position_scaling i_feedback_position_scaling (.clk(clk),
    .sys_rst(sysRst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regAck(regAck), .regError(regError), .rawPosition(rawPosition),
    .followError(followError), .gearNumerator(gearNumerator),
    .motorPoleCount(motorPoleCount), .driveEnableReq(driveEnableReq),
    .faultClear(faultClear), .stBitsIn(stBitsIn), .mtBitsIn(mtBitsIn),
    .multiturnDevice(multiturnDevice), .mtInitSupported(mtInitSupported),
    .primaryPosition(primaryPosition), .positionReport(positionReport),
    .fieldbusPosition(fieldbusPosition),
    .fieldbusFollowError(fieldbusFollowError),
    .commutationPoles(commutationPoles), .velocityPoles(velocityPoles),
    .enableGranted(enableGranted), .driveFault(driveFault),
    .mtInitPulse(mtInitPulse), .positionUnit(positionUnit));

  feedback_device_model i_feedback_device_model (.clk(clk),
    .rawPosition(rawPosition), .followError(followError),
    .stBitsIn(stBitsIn), .mtBitsIn(mtBitsIn),
    .multiturnDevice(multiturnDevice), .mtInitSupported(mtInitSupported));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic final_report;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic checkVal(input string what, input logic [63:0] exp,
      input logic [63:0] got);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic checkBit(input string what, input logic exp,
      input logic got);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one parameter access; answer is taken one edge after the strobe edge
  task automatic busOp(input logic wr, input logic [15:0] a,
      input logic [63:0] d);
    @(posedge clk);
    regWrite <= wr;
    regRead <= ~wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    #1;
    gotAck = regAck;
    gotErr = regError;
    gotData = regRdata;
    gotInit = mtInitPulse;
    checkBit("regAck", 1'b1, gotAck);
  endtask

  task automatic wrChk(input logic [15:0] a, input logic [63:0] d,
      input logic expErr);
    busOp(1'b1, a, d);
    checkBit("regError on write", expErr, gotErr);
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [63:0] exp);
    busOp(1'b0, a, 64'h0);
    checkBit("regError on read", 1'b0, gotErr);
    checkVal("regRdata", exp, gotData);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic testReset;
    rdChk(`REG_POLE_COUNT, 64'h2);
    rdChk(`REG_POS_SHIFT, 64'h14);
    rdChk(`REG_POS_OFFSET, 64'h0);
    rdChk(`REG_POS_UNIT, 64'h0);
    checkVal("commutationPoles", 64'h2, commutationPoles);
    checkVal("velocityPoles", 64'h2, velocityPoles);
    busOp(1'b0, 16'h0001, 64'h0);
    checkBit("unmapped read error", 1'b1, gotErr);
    checkVal("unmapped read data", 64'h0, gotData);
    $display("test reset done");
  endtask

  task automatic testScaling;
    i_feedback_device_model.setPos(64'h000000231234ABCD,
      64'h0000000180000000);
    settle(3);
    checkVal("primaryPosition", 64'h000000231234ABCD,
      primaryPosition);
    checkVal("fieldbusPosition", 64'h0231234A, fieldbusPosition);
    checkVal("fieldbusFollowError", 64'h00180000,
      fieldbusFollowError);
    wrChk(`REG_POS_SHIFT, 64'h10, 1'b0);
    settle(3);
    checkVal("fieldbusPosition", 64'h00231234, fieldbusPosition);
    wrChk(`REG_POS_SHIFT, 64'h20, 1'b0);
    settle(3);
    checkVal("fieldbusPosition", 64'h1234ABCD, fieldbusPosition);
    wrChk(`REG_POS_SHIFT, 64'h21, 1'b1);
    rdChk(`REG_POS_SHIFT, 64'h20);
    wrChk(`REG_POS_SHIFT, 64'h0, 1'b0);
    settle(3);
    checkVal("fieldbusPosition", 64'h23, fieldbusPosition);
    wrChk(`REG_POS_SHIFT, 64'h14, 1'b0);
    // offset travels as one signed 64-bit word, never as halves
    i_feedback_device_model.setPos(64'h2710, 64'h0);
    wrChk(`REG_POS_OFFSET, 64'hFFFFFFFFFFFFD8F0, 1'b0);
    settle(3);
    checkVal("primaryPosition", 64'h0, primaryPosition);
    rdChk(`REG_POS_OFFSET, 64'hFFFFFFFFFFFFD8F0);
    wrChk(`REG_POS_OFFSET, 64'h0, 1'b0);
    $display("test scaling done");
  endtask

  task automatic testRanges;
    wrChk(`REG_POLE_COUNT, 64'h1, 1'b1);
    wrChk(`REG_POLE_COUNT, 64'h81, 1'b1);
    wrChk(`REG_POLE_COUNT, 64'h80, 1'b0);
    rdChk(`REG_POLE_COUNT, 64'h80);
    settle(2);
    checkVal("velocityPoles", 64'h80, velocityPoles);
    wrChk(`REG_POS_UNIT, 64'h1, 1'b1);
    wrChk(`REG_POS_UNIT, 64'h2, 1'b1);
    wrChk(`REG_POS_UNIT, 64'h3, 1'b0);
    i_feedback_device_model.setPos(64'h0000000280000000, 64'h0);
    settle(4);
    checkVal("positionUnit", 64'h3, positionUnit);
    checkVal("positionReport", 64'h9C4, positionReport);
    wrChk(`REG_POS_UNIT, 64'h0, 1'b0);
    settle(4);
    checkVal("positionReport", 64'h0000000280000000,
      positionReport);
    $display("test ranges done");
  endtask

  // one enable attempt, then drop the request and clear any fault
  task automatic enableRun(input logic [15:0] motor, input logic [15:0] fb,
      input logic expOk);
    int n;
    wrChk(`REG_POLE_COUNT, {48'h0, fb}, 1'b0);
    @(posedge clk);
    motorPoleCount <= motor;
    driveEnableReq <= 1'b1;
    n = 0;
    do begin
      settle(1);
      n++;
    end while (enableGranted !== 1'b1 && driveFault !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      final_report();
    end
    checkBit("enableGranted", expOk, enableGranted);
    checkBit("driveFault", ~expOk, driveFault);
    @(posedge clk);
    driveEnableReq <= 1'b0;
    faultClear <= 1'b1;
    @(posedge clk);
    faultClear <= 1'b0;
    settle(2);
    checkBit("enableGranted released", 1'b0, enableGranted);
    checkBit("driveFault cleared", 1'b0, driveFault);
  endtask

  task automatic testEnable;
    enableRun(16'h0006, 16'h0004, 1'b0);
    enableRun(16'h0006, 16'h0003, 1'b1);
    enableRun(16'h0080, 16'h0080, 1'b1);
    $display("test enable done");
  endtask

  task automatic testBits;
    i_feedback_device_model.setDev(6'h11, 6'h0C, 1'b1, 1'b1);
    rdChk(`REG_ST_BITS, 64'h11);
    rdChk(`REG_MT_BITS, 64'h0C);
    wrChk(`REG_ST_BITS, 64'h5, 1'b1);
    wrChk(`REG_MT_INIT, 64'h1, 1'b0);
    checkBit("mtInitPulse", 1'b1, gotInit);
    rdChk(`REG_MT_INIT, 64'h0);
    wrChk(`REG_MT_INIT, 64'h2, 1'b1);
    i_feedback_device_model.setDev(6'h11, 6'h0C, 1'b0, 1'b0);
    rdChk(`REG_MT_BITS, 64'h0);
    wrChk(`REG_MT_INIT, 64'h1, 1'b0);
    checkBit("mtInitPulse", 1'b0, gotInit);
    $display("test bits done");
  endtask

  // main sequence: reset for five cycles, then every scenario in turn
  initial begin
    repeat (5) @(posedge clk);
    sysRst <= 1'b0;
    testReset();
    testScaling();
    testRanges();
    testEnable();
    testBits();
    final_report();
  end
endmodule
